// ---- pkg/lcs_pkg.sv ----
// package of the logic cell storage block: register map, field positions,
// reset values and selector codes.
// assumes an apb slave with 32-bit data and byte addresses on paddr.
package lcs_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] ADDR_CELL_CFG = 8'h00;
  localparam logic [7:0] ADDR_TABLE_C = 8'h04;
  localparam logic [7:0] ADDR_PAD_CFG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // ***************************************************************
  // cell configuration fields
  // ***************************************************************
  localparam int CC_DSEL0_LSB = 0;
  localparam int CC_DSEL1_LSB = 2;
  localparam int CC_XSEL = 4;
  localparam int CC_YSEL = 5;
  localparam int CC_EN_SRC_LSB = 6;
  localparam int CC_PC_SRC_LSB = 8;
  localparam int CC_DIN_SRC_LSB = 10;
  localparam int CC_TIN1_SRC_LSB = 12;
  localparam int CC_SET0 = 14;
  localparam int CC_SET1 = 15;
  localparam int CC_INV0 = 16;
  localparam int CC_INV1 = 17;
  localparam int CC_LATCH = 18;
  localparam int CC_EN_USED0 = 19;
  localparam int CC_EN_USED1 = 20;
  localparam int CC_PC_USED0 = 21;
  localparam int CC_PC_USED1 = 22;
  localparam int CC_WIDTH = 23;

  // ***************************************************************
  // pad configuration fields
  // ***************************************************************
  localparam int PC_LATCH = 0;
  localparam int PC_GATE_INV = 1;
  localparam int PC_SET = 2;
  localparam int PC_EN_USED = 3;
  localparam int PC_ROUTE_A_REG = 4;
  localparam int PC_ROUTE_B_REG = 5;
  localparam int PC_WIDTH = 6;

  // ***************************************************************
  // status fields
  // ***************************************************************
  localparam int ST_Q0 = 0;
  localparam int ST_Q1 = 1;
  localparam int ST_PAD_Q = 2;
  localparam int ST_X = 3;
  localparam int ST_Y = 4;
  localparam int ST_TABLE_C = 5;

  // ***************************************************************
  // reset values: reset type, enable and preset/clear unconnected
  // ***************************************************************
  localparam logic [CC_WIDTH-1:0] CELL_CFG_RST = 23'h000000;
  localparam logic [7:0] TABLE_C_RST = 8'h00;
  localparam logic [PC_WIDTH-1:0] PAD_CFG_RST = 6'h00;
  localparam logic CFG_INIT_RST = 1'b1;

  // ***************************************************************
  // storage data source codes
  // ***************************************************************
  typedef enum logic [1:0] {
    LCS_SRC_TABLE_A = 2'h0,
    LCS_SRC_TABLE_B = 2'h1,
    LCS_SRC_TABLE_C = 2'h2,
    LCS_SRC_DIRECT = 2'h3
  } lcs_dsrc_t;

endpackage : lcs_pkg

// ---- pkg/lcs_store_if.sv ----
// interface between the cell/pad control logic and one storage element.
// assumes one clock pclk drives both ends.
`timescale 1ns/100ps
interface lcs_store_if;
  logic d;
  logic edge_hit;
  logic gate_open;
  logic en;
  logic force_val;
  logic set_val;
  logic latch;
  logic q;

  modport elem (
    input d,
    input edge_hit,
    input gate_open,
    input en,
    input force_val,
    input set_val,
    input latch,
    output q
  );

  modport ctrl (
    output d,
    output edge_hit,
    output gate_open,
    output en,
    output force_val,
    output set_val,
    output latch,
    input q
  );
endinterface : lcs_store_if

// ---- verilog/lcs_store.sv ----
// one storage element: edge flip-flop or level latch with forced value.
// assumes trigger edges and gate levels come already decoded on pclk.
`timescale 1ns/100ps
module lcs_store (
  input wire logic pclk,
  input wire logic presetn,
  lcs_store_if.elem s
);

  // ***************************************************************
  // next value
  // ***************************************************************
  logic q_reg;
  logic q_next;
  logic take_d;

  // latch passes while open, flip-flop only on its decoded edge
  assign take_d = s.latch ? s.gate_open : s.edge_hit;

  always_comb begin
    q_next = q_reg;
    if (s.force_val) begin
      q_next = s.set_val;
    end else if (s.en && take_d) begin
      q_next = s.d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign s.q = q_reg;

endmodule : lcs_store

// ---- verilog/lcs_top.sv ----
// logic cell storage and routing selects plus pad input register, apb view.
// assumes all pins synchronous to pclk; table a/b outputs come from outside.
//
// Operation
// - two cell storage elements share trigger, enable and preset/clear lines
// - direct input or table c output can feed either element; third-table input one only reaches table c
// - each element data picks table a, b, c or direct input
// - output x picks table a or c; output y picks table b or c
// - any of four control inputs may drive any internal control
// - table c inputs: preset/clear bit 0, input one bit 1, direct bit 2
// - preset/clear high forces configured value, ignoring trigger and enable
// - per-element set or reset type drives init and preset/clear value
// - unused preset/clear is inactive; not invertible; reset type by default
// - per-element inversion picks rising or falling trigger edge
// - enable active high; flip-flop loads on active edge only when enabled
// - an element with unconnected enable stays always enabled
// - enable low holds output in both modes; enable not invertible
// - optional latch mode: transparent while gate low and enabled
// - both cell latches share one gate line and one enable
// - pad input goes direct or through flip-flop or latch register
// - pad flip-flop captures rising edge, latch open high, inversion optional
// - pad register loads set/reset on init; holds with enable low
// - each pad route independently carries direct or registered signal
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
module lcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] cell_control_inputs,
  input wire logic storage_trigger_line,
  input wire logic table_four_a,
  input wire logic table_four_b,
  input wire logic global_init_pulse,
  input wire logic pad_in,
  input wire logic pad_trigger_line,
  input wire logic pad_enable,
  output logic cell_q0,
  output logic cell_q1,
  output logic comb_x,
  output logic comb_y,
  output logic pad_route_a,
  output logic pad_route_b
);

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  logic [lcs_pkg::CC_WIDTH-1:0] cell_cfg_reg;
  logic [7:0] table_c_reg;
  logic [lcs_pkg::PC_WIDTH-1:0] pad_cfg_reg;
  logic cfg_init_reg;

  // ***************************************************************
  // apb decode
  // ***************************************************************
  logic setup_phase;
  logic wr_go;
  logic hit_cell;
  logic hit_table;
  logic hit_pad;
  logic hit_status;
  logic addr_ok;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;

  assign setup_phase = psel && !penable;
  // writes land only at the edge where the access completes
  assign wr_go = psel && penable && pwrite && pready_reg;
  assign hit_cell = (paddr == lcs_pkg::ADDR_CELL_CFG);
  assign hit_table = (paddr == lcs_pkg::ADDR_TABLE_C);
  assign hit_pad = (paddr == lcs_pkg::ADDR_PAD_CFG);
  assign hit_status = (paddr == lcs_pkg::ADDR_STATUS);
  assign addr_ok = hit_cell || hit_table || hit_pad || hit_status;
  assign prdata_next = pwrite ? 32'h00000000 : rd_word;

  always_comb begin
    if (hit_cell) begin
      rd_word = {{(32 - lcs_pkg::CC_WIDTH){1'b0}}, cell_cfg_reg};
    end else if (hit_table) begin
      rd_word = {24'h000000, table_c_reg};
    end else if (hit_pad) begin
      rd_word = {{(32 - lcs_pkg::PC_WIDTH){1'b0}}, pad_cfg_reg};
    end else if (hit_status) begin
      rd_word = status_word;
    end else begin
      rd_word = 32'h00000000;
    end
  end

  // read data is captured in setup so it holds still through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      if (setup_phase) begin
        prdata_reg <= prdata_next;
      end
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !addr_ok;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ***************************************************************
  // register writes
  // ***************************************************************
  // status is read only; a write there is accepted and dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_cfg_reg <= lcs_pkg::CELL_CFG_RST;
      table_c_reg <= lcs_pkg::TABLE_C_RST;
      pad_cfg_reg <= lcs_pkg::PAD_CFG_RST;
    end else if (wr_go) begin
      if (hit_cell) begin
        cell_cfg_reg <= pwdata[lcs_pkg::CC_WIDTH-1:0];
      end
      if (hit_table) begin
        table_c_reg <= pwdata[7:0];
      end
      if (hit_pad) begin
        pad_cfg_reg <= pwdata[lcs_pkg::PC_WIDTH-1:0];
      end
    end
  end

  // one init cycle after reset release stands for end of configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_init_reg <= lcs_pkg::CFG_INIT_RST;
    end else begin
      cfg_init_reg <= 1'b0;
    end
  end

  // ***************************************************************
  // configuration fields
  // ***************************************************************
  logic [1:0] dsel0;
  logic [1:0] dsel1;
  logic [1:0] en_src;
  logic [1:0] pc_src;
  logic [1:0] din_src;
  logic [1:0] tin1_src;

  assign dsel0 = cell_cfg_reg[lcs_pkg::CC_DSEL0_LSB +: 2];
  assign dsel1 = cell_cfg_reg[lcs_pkg::CC_DSEL1_LSB +: 2];
  assign en_src = cell_cfg_reg[lcs_pkg::CC_EN_SRC_LSB +: 2];
  assign pc_src = cell_cfg_reg[lcs_pkg::CC_PC_SRC_LSB +: 2];
  assign din_src = cell_cfg_reg[lcs_pkg::CC_DIN_SRC_LSB +: 2];
  assign tin1_src = cell_cfg_reg[lcs_pkg::CC_TIN1_SRC_LSB +: 2];

  // ***************************************************************
  // control selectors and table c
  // ***************************************************************
  logic storage_enable;
  logic async_preset_clear;
  logic direct_in;
  logic third_table_input_one;
  logic [2:0] table_c_idx;
  logic table_three_c;

  assign storage_enable = cell_control_inputs[en_src];
  assign async_preset_clear = cell_control_inputs[pc_src];
  assign direct_in = cell_control_inputs[din_src];
  assign third_table_input_one = cell_control_inputs[tin1_src];

  // control lines double as table inputs, so the table still sees them
  assign table_c_idx = {direct_in, third_table_input_one, async_preset_clear};
  assign table_three_c = table_c_reg[table_c_idx];

  // ***************************************************************
  // data and output selectors
  // ***************************************************************
  logic [3:0] data_pool;
  logic d0;
  logic d1;
  logic x_next;
  logic y_next;

  assign data_pool = {direct_in, table_three_c, table_four_b, table_four_a};
  assign d0 = data_pool[dsel0];
  assign d1 = data_pool[dsel1];
  assign x_next = cell_cfg_reg[lcs_pkg::CC_XSEL] ? table_three_c : table_four_a;
  assign y_next = cell_cfg_reg[lcs_pkg::CC_YSEL] ? table_three_c : table_four_b;

  // ***************************************************************
  // trigger line decode
  // ***************************************************************
  logic trig_prev_reg;
  logic pad_trig_prev_reg;
  logic eff0;
  logic eff0_prev;
  logic eff1;
  logic eff1_prev;
  logic pad_eff;
  logic pad_eff_prev;
  logic init_all;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_reg <= 1'b0;
      pad_trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= storage_trigger_line;
      pad_trig_prev_reg <= pad_trigger_line;
    end
  end

  // both elements watch one line, each through its own inverter
  assign eff0 = storage_trigger_line ^ cell_cfg_reg[lcs_pkg::CC_INV0];
  assign eff0_prev = trig_prev_reg ^ cell_cfg_reg[lcs_pkg::CC_INV0];
  assign eff1 = storage_trigger_line ^ cell_cfg_reg[lcs_pkg::CC_INV1];
  assign eff1_prev = trig_prev_reg ^ cell_cfg_reg[lcs_pkg::CC_INV1];
  assign pad_eff = pad_trigger_line ^ pad_cfg_reg[lcs_pkg::PC_GATE_INV];
  assign pad_eff_prev = pad_trig_prev_reg ^ pad_cfg_reg[lcs_pkg::PC_GATE_INV];

  // sampled on pclk, so init takes effect at the next edge, not instantly
  assign init_all = global_init_pulse || cfg_init_reg;

  // ***************************************************************
  // cell storage elements
  // ***************************************************************
  lcs_store_if cell0_if ();
  lcs_store_if cell1_if ();
  lcs_store_if pad_if ();

  assign cell0_if.d = d0;
  assign cell0_if.edge_hit = eff0 && !eff0_prev;
  assign cell0_if.gate_open = !eff0;
  // unconnected enable reads as always active; no inverter on it
  assign cell0_if.en = !cell_cfg_reg[lcs_pkg::CC_EN_USED0] || storage_enable;
  assign cell0_if.force_val = init_all
    || (cell_cfg_reg[lcs_pkg::CC_PC_USED0] && async_preset_clear);
  assign cell0_if.set_val = cell_cfg_reg[lcs_pkg::CC_SET0];
  assign cell0_if.latch = cell_cfg_reg[lcs_pkg::CC_LATCH];

  assign cell1_if.d = d1;
  assign cell1_if.edge_hit = eff1 && !eff1_prev;
  assign cell1_if.gate_open = !eff1;
  assign cell1_if.en = !cell_cfg_reg[lcs_pkg::CC_EN_USED1] || storage_enable;
  assign cell1_if.force_val = init_all
    || (cell_cfg_reg[lcs_pkg::CC_PC_USED1] && async_preset_clear);
  assign cell1_if.set_val = cell_cfg_reg[lcs_pkg::CC_SET1];
  assign cell1_if.latch = cell_cfg_reg[lcs_pkg::CC_LATCH];

  lcs_store u_cell0 (
    .pclk(pclk),
    .presetn(presetn),
    .s(cell0_if.elem)
  );

  lcs_store u_cell1 (
    .pclk(pclk),
    .presetn(presetn),
    .s(cell1_if.elem)
  );

  // ***************************************************************
  // pad input register
  // ***************************************************************
  // the pad register has no preset/clear line, only init
  assign pad_if.d = pad_in;
  assign pad_if.edge_hit = pad_eff && !pad_eff_prev;
  assign pad_if.gate_open = pad_eff;
  assign pad_if.en = !pad_cfg_reg[lcs_pkg::PC_EN_USED] || pad_enable;
  assign pad_if.force_val = init_all;
  assign pad_if.set_val = pad_cfg_reg[lcs_pkg::PC_SET];
  assign pad_if.latch = pad_cfg_reg[lcs_pkg::PC_LATCH];

  lcs_store u_pad (
    .pclk(pclk),
    .presetn(presetn),
    .s(pad_if.elem)
  );

  // ***************************************************************
  // registered outputs
  // ***************************************************************
  logic comb_x_reg;
  logic comb_y_reg;
  logic route_a_reg;
  logic route_b_reg;
  logic route_a_next;
  logic route_b_next;

  // a registered route adds the element's own pclk on top of this flop
  assign route_a_next = pad_cfg_reg[lcs_pkg::PC_ROUTE_A_REG] ? pad_if.q : pad_in;
  assign route_b_next = pad_cfg_reg[lcs_pkg::PC_ROUTE_B_REG] ? pad_if.q : pad_in;

  // direct routes cost one pclk so every output leaves from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comb_x_reg <= 1'b0;
      comb_y_reg <= 1'b0;
      route_a_reg <= 1'b0;
      route_b_reg <= 1'b0;
    end else begin
      comb_x_reg <= x_next;
      comb_y_reg <= y_next;
      route_a_reg <= route_a_next;
      route_b_reg <= route_b_next;
    end
  end

  assign cell_q0 = cell0_if.q;
  assign cell_q1 = cell1_if.q;
  assign comb_x = comb_x_reg;
  assign comb_y = comb_y_reg;
  assign pad_route_a = route_a_reg;
  assign pad_route_b = route_b_reg;

  // ***************************************************************
  // status word
  // ***************************************************************
  always_comb begin
    status_word = 32'h00000000;
    status_word[lcs_pkg::ST_Q0] = cell0_if.q;
    status_word[lcs_pkg::ST_Q1] = cell1_if.q;
    status_word[lcs_pkg::ST_PAD_Q] = pad_if.q;
    status_word[lcs_pkg::ST_X] = comb_x_reg;
    status_word[lcs_pkg::ST_Y] = comb_y_reg;
    status_word[lcs_pkg::ST_TABLE_C] = table_three_c;
  end

endmodule : lcs_top

// ---- sim/lcs_checker.sv ----
// checker of lcs_top: apb answer timing, output selects, init and pad hold.
// assumes it is bound to lcs_top and sees its ports only.
`timescale 1ns/100ps
module lcs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic table_four_a,
  input wire logic table_four_b,
  input wire logic global_init_pulse,
  input wire logic pad_in,
  input wire logic pad_enable,
  input wire logic cell_q0,
  input wire logic cell_q1,
  input wire logic comb_x,
  input wire logic comb_y,
  input wire logic pad_route_a
);
  logic [22:0] cc_reg;
  logic [5:0] pc_reg;
  wire logic wr_hit = psel && penable && pready && pwrite;

  // ***************************************************************
  // shadow of the configuration, so no check needs to peek inside
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_reg <= lcs_pkg::CELL_CFG_RST;
      pc_reg <= lcs_pkg::PAD_CFG_RST;
    end else if (wr_hit && paddr == lcs_pkg::ADDR_CELL_CFG) begin
      cc_reg <= pwdata[22:0];
    end else if (wr_hit && paddr == lcs_pkg::ADDR_PAD_CFG) begin
      pc_reg <= pwdata[5:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_setup:
    assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single:
    assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside one access cycle");
  a_err_decode:
    assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
    else $error("pslverr does not match decode");
  a_rdata_zero:
    assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_init_force:
    assert property (global_init_pulse [*2] |=> cell_q0 == cc_reg[lcs_pkg::CC_SET0]
      && cell_q1 == cc_reg[lcs_pkg::CC_SET1])
    else $error("init did not force set value");
  a_x_select:
    assert property ($past(presetn && !cc_reg[lcs_pkg::CC_XSEL]) |-> comb_x == $past(table_four_a))
    else $error("comb_x not table a");
  a_y_select:
    assert property ($past(presetn && !cc_reg[lcs_pkg::CC_YSEL]) |-> comb_y == $past(table_four_b))
    else $error("comb_y not table b");
  a_route_direct:
    assert property ($past(presetn && !pc_reg[lcs_pkg::PC_ROUTE_A_REG])
      |-> pad_route_a == $past(pad_in))
    else $error("pad_route_a not direct");
  a_pad_hold:
    assert property ($past(pc_reg[lcs_pkg::PC_EN_USED] && pc_reg[lcs_pkg::PC_ROUTE_A_REG]
      && !pad_enable && !global_init_pulse)
      && $stable(pc_reg) |=> $stable(pad_route_a))
    else $error("pad register moved while disabled");
endmodule : lcs_checker

bind lcs_top lcs_checker lcs_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .table_four_a, .table_four_b, .global_init_pulse,
  .pad_in, .pad_enable, .cell_q0, .cell_q1, .comb_x, .comb_y, .pad_route_a);

// ---- sim/lcs_top_tb.sv ----
// testbench of lcs_top: registers, selects, cell storage and pad register.
// assumes lcs_top with one 50 MHz clock and no parameters.
`timescale 1ns/100ps
module lcs_top_tb;
  typedef struct packed {
    logic [22:0] cc;
    logic [7:0] tc;
    logic [3:0] ctl;
    logic a;
    logic b;
    logic x;
    logic y;
  } lcs_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] cell_control_inputs;
  logic storage_trigger_line, table_four_a, table_four_b, global_init_pulse;
  logic pad_in, pad_trigger_line, pad_enable;
  logic cell_q0, cell_q1, comb_x, comb_y, pad_route_a, pad_route_b;
  int fail_count = 0;
  int cmp_count = 0;
  lcs_row_t rows[6] = '{'{23'h0, 8'h0, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0},
    '{23'h0, 8'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1},
    '{23'h002d30, 8'h80, 4'he, 1'b0, 1'b0, 1'b1, 1'b1},
    '{23'h002d30, 8'h80, 4'hc, 1'b1, 1'b1, 1'b0, 1'b0},
    '{23'h001310, 8'h02, 4'h8, 1'b0, 1'b0, 1'b1, 1'b0},
    '{23'h001310, 8'h02, 4'h9, 1'b0, 1'b1, 1'b0, 1'b1}};

  lcs_top lcs_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cell_control_inputs, .storage_trigger_line, .table_four_a,
    .table_four_b, .global_init_pulse, .pad_in, .pad_trigger_line, .pad_enable, .cell_q0,
    .cell_q1, .comb_x, .comb_y, .pad_route_a, .pad_route_b);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // request held until pready is seen high; no fixed wait assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
    check("pslverr", 32'(er), 32'(ee));
  endtask : rchk

  task automatic drv(input logic [3:0] c, input logic t, input logic a, input logic e0,
    input logic e1);
    @(posedge pclk);
    cell_control_inputs <= c;
    storage_trigger_line <= t;
    table_four_a <= a;
    repeat (3) @(posedge pclk);
    check("cell_q0", 32'(cell_q0), 32'(e0));
    check("cell_q1", 32'(cell_q1), 32'(e1));
  endtask : drv

  task automatic pdrv(input logic i, input logic t, input logic e, input logic ea,
    input logic eb);
    @(posedge pclk);
    pad_in <= i;
    pad_trigger_line <= t;
    pad_enable <= e;
    repeat (3) @(posedge pclk);
    check("pad_route_a", 32'(pad_route_a), 32'(ea));
    check("pad_route_b", 32'(pad_route_b), 32'(eb));
  endtask : pdrv

  task automatic pulse_init;
    @(posedge pclk);
    global_init_pulse <= 1'b1;
    repeat (2) @(posedge pclk);
    global_init_pulse <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse_init

  // a hang is cut short well after the few hundred cycles the tests take
  initial begin
    repeat (4000) @(posedge pclk);
    fail_count++;
    report_and_stop();
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {cell_control_inputs, storage_trigger_line, table_four_a, table_four_b} = '0;
    {global_init_pulse, pad_in, pad_trigger_line, pad_enable} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk("cell_cfg", 8'h00, 32'h0, 1'b0);
    rchk("table_c", 8'h04, 32'h0, 1'b0);
    rchk("pad_cfg", 8'h08, 32'h0, 1'b0);
    check("cell_q0", 32'(cell_q0), 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, 8'h00, 32'(rows[i].cc));
      apb(1'b1, 8'h04, 32'(rows[i].tc));
      @(posedge pclk);
      cell_control_inputs <= rows[i].ctl;
      table_four_a <= rows[i].a;
      table_four_b <= rows[i].b;
      repeat (3) @(posedge pclk);
      check("comb_x", 32'(comb_x), 32'(rows[i].x));
      check("comb_y", 32'(comb_y), 32'(rows[i].y));
    end
    $display("select rows done");
    apb(1'b1, 8'h00, 32'h00100403);
    drv(4'h3, 1'b0, 1'b1, 1'b0, 1'b0);
    drv(4'h3, 1'b1, 1'b1, 1'b1, 1'b1);
    drv(4'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    drv(4'h0, 1'b1, 1'b0, 1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h00120403);
    drv(4'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h00708603);
    drv(4'h3, 1'b1, 1'b0, 1'b1, 1'b0);
    drv(4'h7, 1'b1, 1'b0, 1'b0, 1'b1);
    drv(4'h7, 1'b0, 1'b1, 1'b0, 1'b1);
    drv(4'h7, 1'b1, 1'b1, 1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h00108603);
    drv(4'h7, 1'b0, 1'b0, 1'b0, 1'b1);
    drv(4'h7, 1'b1, 1'b0, 1'b1, 1'b0);
    pulse_init();
    check("cell_q0", 32'(cell_q0), 32'h0);
    check("cell_q1", 32'(cell_q1), 32'h1);
    apb(1'b1, 8'h00, 32'h000c0403);
    drv(4'h3, 1'b1, 1'b0, 1'b0, 1'b1);
    drv(4'h3, 1'b0, 1'b0, 1'b1, 1'b0);
    drv(4'h1, 1'b0, 1'b1, 1'b0, 1'b1);
    drv(4'h2, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("storage test done");
    pdrv(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    apb(1'b1, 8'h08, 32'h18);
    pdrv(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    pdrv(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    pdrv(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    pdrv(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    apb(1'b1, 8'h08, 32'h19);
    pdrv(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    pdrv(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    apb(1'b1, 8'h08, 32'h1d);
    pulse_init();
    check("pad_route_a", 32'(pad_route_a), 32'h1);
    apb(1'b1, 8'h08, 32'h1b);
    pdrv(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    $display("pad test done");
    apb(1'b1, 8'h10, 32'hffffffff);
    apb(1'b1, 8'h0c, 32'h3f);
    apb(1'b1, 8'h00, 32'hff8c0403);
    rchk("cell_cfg", 8'h00, 32'h000c0403, 1'b0);
    rchk("status", 8'h0c, 32'h10, 1'b0);
    rchk("unmapped", 8'h10, 32'h0, 1'b1);
    $display("apb test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("comb_y", 32'(comb_y), 32'h0);
    presetn <= 1'b1;
    rchk("cell_cfg", 8'h00, 32'h0, 1'b0);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule : lcs_top_tb
